// *** dslc_pkg.sv ***
// Purpose: Shared constants for the serial load control of a 20-bit converter.
// Assumes: One 10 MHz system clock at both ends; link pins sampled through two flops.
// Notes: Contract
// Contract
// (R1) Frames are 24 bits, MSB first
// (R2) Bit 23 read flag, 3 address, 20 data
// (R3) Write addresses: code, control, clear, software control
// (R4) Read addresses 1-3; address 0 is no-op
// (R5) Host shift clock at most 35 MHz
// (R6) Frame starts at frame-select falling edge
// (R7) Host gives exactly 24 falling edges
// (R8) Wrong edge count discards the frame
// (R9) Frame-select rise latches and routes data
// (R10) Read data shifts out next frame
// (R11) Serial out released while frame-select high
// (R12) Next read overlaps previous readback
// (R13) Serial out enabled after reset
// (R14) Load low: update at frame end
// (R15) Load high: update on load falling edge
// (R16) Reset pin low blocks programming
// (R17) Hardware or software reset restores defaults
// (R18) Clear low loads clear code into code
// (R19) No new code while clear low
// (R20) Output keeps clear value after clear
// (R21) Software clear bit equals clear pin
// (R22) Top 6 bits thermometer, 14 binary
// (R23) Sample data on falling shift-clock edge
package dslc_pkg;
	localparam int FRAME_BITS = 24;
	localparam int DATA_BITS = 20;
	localparam int ADDR_BITS = 3;
	localparam int RW_POS = 23;
	localparam int ADDR_HI = 22;
	localparam int ADDR_LO = 20;
	localparam logic [2:0] ADDR_NOP = 3'h0;
	localparam logic [2:0] ADDR_CODE = 3'h1;
	localparam logic [2:0] ADDR_CTRL = 3'h2;
	localparam logic [2:0] ADDR_CLRCODE = 3'h3;
	localparam logic [2:0] ADDR_SWCTRL = 3'h4;
	localparam logic [19:0] CODE_RST = 20'h00000;
	localparam logic [19:0] CTRL_RST = 20'h00000;
	localparam logic [19:0] CLRCODE_RST = 20'h00000;
	localparam int CTRL_OUTDIS_POS = 5;
	localparam int SW_LOAD_POS = 0;
	localparam int SW_CLEAR_POS = 1;
	localparam int SW_RESET_POS = 2;
	localparam int SEG_BITS = 6;
	localparam int SEG_COUNT = 63;
	localparam int BIN_BITS = 14;
	localparam int SYS_CLK_MHZ = 10;
	localparam int LINK_MAX_MHZ = 35;
	localparam int LINK_HALF_CYC = 4;
	localparam int CNT_W = 5;
endpackage : dslc_pkg

// *** dslc_link_if.sv ***
// Purpose: Pins between the host controller and the converter front end.
// Assumes: Serial out wire resolved from its enable.
// Notes: Undriven serial out reads as high.
interface dslc_link_if;
	logic frameSelN;
	logic shiftClk;
	logic serialInLine;
	logic serialOutO;
	logic serialOutOe;
	logic loadOutputN;
	logic clearToCodeN;
	logic resetN;
	wire serialOutLine;
	assign serialOutLine = serialOutOe ? serialOutO : 1'b1;
	modport host (output frameSelN, output shiftClk, output serialInLine, output loadOutputN,
		output clearToCodeN, output resetN, input serialOutLine);
	modport device (input frameSelN, input shiftClk, input serialInLine, input loadOutputN,
		input clearToCodeN, input resetN, output serialOutO, output serialOutOe);
endinterface : dslc_link_if

// *** dslc_sync.sv ***
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Inputs asynchronous to clk.
// Notes: First stage is read only by the second.
module dslc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] rstVal,
	// Levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;
	always_comb
	begin
		meta_nxt = din;
		sync_nxt = meta_r;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_r <= '1;
			sync_r <= '1;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end
	assign dout = sync_r;
endmodule : dslc_sync

// *** dslc_device.sv ***
// Purpose: Converter front end: frame capture, register decode, update and clear.
// Assumes: Link pins sampled at 10 MHz; host keeps link timing.
// Notes: Pins idle high; sync reset vector is all ones.
module dslc_device
	import dslc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link
	dslc_link_if.device link,
	// Converter outputs
	output logic [SEG_COUNT-1:0] segCtrl,
	output logic [BIN_BITS-1:0] binCtrl,
	output logic [DATA_BITS-1:0] codeOut,
	output logic [DATA_BITS-1:0] ctrlOut,
	output logic frameError
);
	function automatic logic [SEG_COUNT-1:0] thermo(input logic [SEG_BITS-1:0] v);
		logic [SEG_COUNT-1:0] t;
		t = '0;
		for (int i = 0; i < SEG_COUNT; i++)
			t[i] = (i < int'(v));
		return t;
	endfunction : thermo

	logic [5:0] pins;
	logic fsN, sck, sdi, ldN, clrN, rstPinN;
	dslc_sync #(.W(6)) uSync (
		.clk(clk),
		.rstn(rstn),
		.rstVal(6'h3f),
		.din({link.frameSelN, link.shiftClk, link.serialInLine, link.loadOutputN,
			link.clearToCodeN, link.resetN}),
		.dout(pins)
	);
	assign {fsN, sck, sdi, ldN, clrN, rstPinN} = pins;

	logic fsN_r, sck_r, ldN_r;
	logic [FRAME_BITS-1:0] shift_r, shift_nxt;
	logic [FRAME_BITS-1:0] out_r, out_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic over_r, over_nxt;
	logic [DATA_BITS-1:0] code_r, code_nxt, ctrl_r, ctrl_nxt, clr_r, clr_nxt;
	logic [DATA_BITS-1:0] inCode_r, inCode_nxt, dacOut_r, dacOut_nxt;
	logic pend_r, pend_nxt, err_r, err_nxt, sdo_r, sdo_nxt, oe_r, oe_nxt;
	logic [SEG_COUNT-1:0] seg_r, seg_nxt;
	logic [BIN_BITS-1:0] bin_r, bin_nxt;

	logic fsFall, fsRise, sckFall, sckRise, ldFall, goodFrame, rwBit, swReset, clrActive;
	logic [2:0] addr;
	logic [DATA_BITS-1:0] fData;

	always_comb
	begin
		fsFall = fsN_r && !fsN;
		fsRise = !fsN_r && fsN;
		sckFall = sck_r && !sck && !fsN; // R23
		sckRise = !sck_r && sck && !fsN;
		ldFall = ldN_r && !ldN;
		goodFrame = fsRise && cnt_r == CNT_W'(FRAME_BITS) && !over_r; // R8 R7
		rwBit = shift_r[RW_POS]; // R2
		addr = shift_r[ADDR_HI:ADDR_LO];
		fData = shift_r[DATA_BITS-1:0];
		swReset = goodFrame && !rwBit && addr == ADDR_SWCTRL && fData[SW_RESET_POS];
		clrActive = !clrN || (goodFrame && !rwBit && addr == ADDR_SWCTRL
			&& fData[SW_CLEAR_POS]); // R18 R21
		shift_nxt = shift_r;
		cnt_nxt = cnt_r;
		over_nxt = over_r;
		out_nxt = out_r;
		sdo_nxt = sdo_r;
		code_nxt = code_r;
		ctrl_nxt = ctrl_r;
		clr_nxt = clr_r;
		inCode_nxt = inCode_r;
		dacOut_nxt = dacOut_r;
		pend_nxt = pend_r;
		err_nxt = err_r;
		if (fsFall)
		begin
			cnt_nxt = '0; // R6
			over_nxt = 1'b0;
			sdo_nxt = out_r[FRAME_BITS-1];
		end
		if (sckFall)
		begin
			shift_nxt = {shift_r[FRAME_BITS-2:0], sdi}; // R1 R23
			if (cnt_r == CNT_W'(FRAME_BITS))
				over_nxt = 1'b1;
			else
				cnt_nxt = cnt_r + 1'b1;
		end
		if (sckRise)
		begin
			out_nxt = {out_r[FRAME_BITS-2:0], 1'b0}; // R10 R12
			sdo_nxt = out_r[FRAME_BITS-2];
		end
		if (fsRise)
		begin
			err_nxt = !goodFrame; // R8
			out_nxt = '0;
		end
		if (goodFrame && rwBit) // R4
		begin
			case (addr)
				ADDR_CODE: out_nxt = {shift_r[FRAME_BITS-1:DATA_BITS], code_r};
				ADDR_CTRL: out_nxt = {shift_r[FRAME_BITS-1:DATA_BITS], ctrl_r};
				ADDR_CLRCODE: out_nxt = {shift_r[FRAME_BITS-1:DATA_BITS], clr_r};
				default: out_nxt = '0;
			endcase
		end
		if (goodFrame && !rwBit) // R3 R9
		begin
			case (addr)
				ADDR_CODE:
				begin
					code_nxt = fData;
					inCode_nxt = fData;
					pend_nxt = 1'b1;
				end
				ADDR_CTRL: ctrl_nxt = fData;
				ADDR_CLRCODE: clr_nxt = fData;
				default: ;
			endcase
		end
		if (pend_nxt && !clrActive && ((goodFrame && !ldN) || (ldFall && fsN)))
		begin
			dacOut_nxt = inCode_nxt; // R14 R15
			pend_nxt = 1'b0;
		end
		if (clrActive)
		begin
			code_nxt = clr_nxt; // R18 R19 R20
			inCode_nxt = clr_nxt;
			dacOut_nxt = clr_nxt;
			pend_nxt = 1'b0;
		end
		oe_nxt = !fsN && !ctrl_r[CTRL_OUTDIS_POS]; // R11 R13
		seg_nxt = thermo(dacOut_r[DATA_BITS-1 -: SEG_BITS]); // R22
		bin_nxt = dacOut_r[BIN_BITS-1:0];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fsN_r <= 1'b1;
			sck_r <= 1'b1;
			ldN_r <= 1'b1;
			shift_r <= '0;
			out_r <= '0;
			cnt_r <= '0;
			over_r <= 1'b0;
			code_r <= CODE_RST;
			ctrl_r <= CTRL_RST;
			clr_r <= CLRCODE_RST;
			inCode_r <= CODE_RST;
			dacOut_r <= CODE_RST;
			pend_r <= 1'b0;
			err_r <= 1'b0;
			sdo_r <= 1'b0;
			oe_r <= 1'b0;
			seg_r <= '0;
			bin_r <= '0;
		end
		else if (!rstPinN || swReset) // R16 R17
		begin
			fsN_r <= fsN;
			sck_r <= sck;
			ldN_r <= ldN;
			shift_r <= '0;
			out_r <= '0;
			cnt_r <= '0;
			over_r <= 1'b0;
			code_r <= CODE_RST;
			ctrl_r <= CTRL_RST;
			clr_r <= CLRCODE_RST;
			inCode_r <= CODE_RST;
			dacOut_r <= CODE_RST;
			pend_r <= 1'b0;
			err_r <= 1'b0;
			sdo_r <= 1'b0;
			oe_r <= 1'b0;
			seg_r <= '0;
			bin_r <= '0;
		end
		else
		begin
			fsN_r <= fsN;
			sck_r <= sck;
			ldN_r <= ldN;
			shift_r <= shift_nxt;
			out_r <= out_nxt;
			cnt_r <= cnt_nxt;
			over_r <= over_nxt;
			code_r <= code_nxt;
			ctrl_r <= ctrl_nxt;
			clr_r <= clr_nxt;
			inCode_r <= inCode_nxt;
			dacOut_r <= dacOut_nxt;
			pend_r <= pend_nxt;
			err_r <= err_nxt;
			sdo_r <= sdo_nxt;
			oe_r <= oe_nxt;
			seg_r <= seg_nxt;
			bin_r <= bin_nxt;
		end
	end

	assign link.serialOutO = sdo_r;
	assign link.serialOutOe = oe_r;
	assign segCtrl = seg_r;
	assign binCtrl = bin_r;
	assign codeOut = dacOut_r;
	assign ctrlOut = ctrl_r;
	assign frameError = err_r;
endmodule : dslc_device

// *** dslc_host.sv ***
// Purpose: Host end: sends one 24-bit frame per request and returns readback.
// Assumes: Shift clock made by dividing clk; pins held by the caller otherwise.
// Notes: Half period LINK_HALF_CYC cycles, far below the link ceiling.
module dslc_host
	import dslc_pkg::*;
#(
	parameter int HALF = LINK_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link
	dslc_link_if.host link,
	// Request
	input wire logic reqValid,
	input wire logic [FRAME_BITS-1:0] reqFrame,
	output logic reqReady,
	// Answer
	output logic rspValid,
	output logic [FRAME_BITS-1:0] rspData,
	// Pins passed through
	input wire logic loadLevelN,
	input wire logic clearLevelN,
	input wire logic resetLevelN
);
	typedef enum logic [1:0] {H_IDLE = 2'b00, H_SHIFT = 2'b01, H_END = 2'b10} dslc_hst_t;
	dslc_hst_t st_r, st_nxt;
	logic [FRAME_BITS-1:0] tx_r, tx_nxt, rx_r, rx_nxt;
	logic [CNT_W-1:0] bit_r, bit_nxt;
	logic [7:0] div_r, div_nxt;
	logic fs_r, fs_nxt, sck_r, sck_nxt, sdi_r, sdi_nxt, rv_r, rv_nxt;
	logic ld_r, cl_r, rs_r, sdoM_r, sdo_r;

	always_comb
	begin
		st_nxt = st_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		bit_nxt = bit_r;
		div_nxt = div_r;
		fs_nxt = fs_r;
		sck_nxt = sck_r;
		sdi_nxt = sdi_r;
		rv_nxt = 1'b0;
		case (st_r)
			H_IDLE:
				if (reqValid)
				begin
					st_nxt = H_SHIFT;
					fs_nxt = 1'b0;
					tx_nxt = {reqFrame[FRAME_BITS-2:0], 1'b0};
					sdi_nxt = reqFrame[FRAME_BITS-1]; // R1
					bit_nxt = '0;
					div_nxt = '0;
				end
			H_SHIFT:
				if (div_r == 8'(HALF - 1)) // R5
				begin
					div_nxt = '0;
					sck_nxt = !sck_r;
					if (!sck_r)
					begin
						rx_nxt = {rx_r[FRAME_BITS-2:0], sdo_r};
						sdi_nxt = tx_r[FRAME_BITS-1];
						tx_nxt = {tx_r[FRAME_BITS-2:0], 1'b0};
					end
					else if (bit_r == CNT_W'(FRAME_BITS - 1))
						st_nxt = H_END; // R7
					else
						bit_nxt = bit_r + 1'b1;
				end
				else
					div_nxt = div_r + 1'b1;
			H_END:
				if (div_r == 8'(HALF - 1))
				begin
					// Last rise returns the clock to idle high and takes readback bit 0
					fs_nxt = 1'b1;
					sck_nxt = 1'b1; // R7
					rx_nxt = {rx_r[FRAME_BITS-2:0], sdo_r}; // R10
					rv_nxt = 1'b1; // R12
					st_nxt = H_IDLE;
				end
				else
					div_nxt = div_r + 1'b1;
			default: st_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r <= H_IDLE;
			tx_r <= '0;
			rx_r <= '0;
			bit_r <= '0;
			div_r <= '0;
			fs_r <= 1'b1;
			sck_r <= 1'b1;
			sdi_r <= 1'b0;
			rv_r <= 1'b0;
			ld_r <= 1'b1;
			cl_r <= 1'b1;
			rs_r <= 1'b0;
			sdoM_r <= 1'b1;
			sdo_r <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			bit_r <= bit_nxt;
			div_r <= div_nxt;
			fs_r <= fs_nxt;
			sck_r <= sck_nxt;
			sdi_r <= sdi_nxt;
			rv_r <= rv_nxt;
			ld_r <= loadLevelN;
			cl_r <= clearLevelN;
			rs_r <= resetLevelN;
			sdoM_r <= link.serialOutLine;
			sdo_r <= sdoM_r;
		end
	end

	assign link.frameSelN = fs_r;
	assign link.shiftClk = sck_r;
	assign link.serialInLine = sdi_r;
	assign link.loadOutputN = ld_r;
	assign link.clearToCodeN = cl_r;
	assign link.resetN = rs_r;
	assign reqReady = st_r == H_IDLE;
	assign rspValid = rv_r;
	assign rspData = rx_r;
endmodule : dslc_host

// *** dslc_link_chk.sv ***
// Purpose: Link-level checks between the host and converter ends.
// Assumes: Shift clock idles high; link pins sampled on clk.
// Notes: Frame length window fits the default half period.
module dslc_link_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link pins
	input wire logic frameSelN,
	input wire logic shiftClk,
	input wire logic serialInLine,
	input wire logic serialOutOe,
	input wire logic loadOutputN,
	input wire logic clearToCodeN
);
	logic [4:0] fallCnt_r;
	logic [4:0] fallCnt_nxt;
	logic clkPrev_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Falling shift edges seen in the current frame
	always_comb
	begin
		fallCnt_nxt = fallCnt_r;
		if (frameSelN)
			fallCnt_nxt = 5'h00;
		else if (clkPrev_r && !shiftClk)
			fallCnt_nxt = fallCnt_r + 5'h01;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fallCnt_r <= 5'h00;
			clkPrev_r <= 1'b1;
		end
		else
		begin
			fallCnt_r <= fallCnt_nxt;
			clkPrev_r <= shiftClk;
		end
	end
	edge_count_a: assert property ($rose(frameSelN) |-> fallCnt_r == 5'h18)
		else $error("frame ended without 24 falling edges");
	out_release_a: assert property (frameSelN [*4] |-> !serialOutOe)
		else $error("serial out driven while idle");
	out_start_a: assert property ($rose(serialOutOe) |-> !frameSelN)
		else $error("serial out enabled outside a frame");
	clock_idle_a: assert property (frameSelN [*3] |-> shiftClk)
		else $error("shift clock active between frames");
	frame_start_a: assert property ($fell(frameSelN) |-> shiftClk)
		else $error("frame began with shift clock low");
	frame_length_a: assert property ($fell(frameSelN) |-> ##[185:200] $rose(frameSelN))
		else $error("frame length out of range");
	data_hold_a: assert property (!frameSelN && $fell(shiftClk) |-> $stable(serialInLine))
		else $error("data moved at sampling edge");
	frame_gap_a: assert property ($rose(frameSelN) |=> frameSelN)
		else $error("frame select gap too short");
	clock_rate_a: assert property ($changed(shiftClk) |=> $stable(shiftClk))
		else $error("shift clock level shorter than two cycles");
	cover property ($rose(frameSelN));
	cover property ($rose(serialOutOe));
	cover property ($fell(loadOutputN));
	cover property ($fell(clearToCodeN));
endmodule : dslc_link_chk

// *** testbench.sv ***
// Purpose: Sends frames through the host end and checks the converter end.
// Assumes: A second converter end is driven by hand for bad frames.
// Notes: Pin changes get eight cycles to cross the synchronisers.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic reqValid = 1'b0;
	logic [23:0] reqFrame = 24'h000000;
	logic ldN = 1'b0;
	logic clrN = 1'b1;
	logic rstN = 1'b1;
	logic sPrev = 1'b1;
	logic reqReady, rspValid, fe, fe2;
	logic [23:0] rspData, wireSeen;
	logic [62:0] seg;
	logic [13:0] bin;
	logic [19:0] code, ctrl;
	int err_total = 0;
	int samples_checked = 0;
	dslc_link_if l1 ();
	dslc_link_if l2 ();
	initial forever #50 clk = ~clk;
	dslc_host i_dslc_host (.clk(clk), .rstn(rstn), .link(l1.host), .reqValid(reqValid),
		.reqFrame(reqFrame), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
		.loadLevelN(ldN), .clearLevelN(clrN), .resetLevelN(rstN));
	dslc_device i_dslc_device (.clk(clk), .rstn(rstn), .link(l1.device), .segCtrl(seg),
		.binCtrl(bin), .codeOut(code), .ctrlOut(ctrl), .frameError(fe));
	dslc_device i_dslc_device_b (.clk(clk), .rstn(rstn), .link(l2.device), .segCtrl(),
		.binCtrl(), .codeOut(), .ctrlOut(), .frameError(fe2));
	dslc_link_chk i_dslc_link_chk (.clk(clk), .rstn(rstn), .frameSelN(l1.frameSelN),
		.shiftClk(l1.shiftClk), .serialInLine(l1.serialInLine), .serialOutOe(l1.serialOutOe),
		.loadOutputN(l1.loadOutputN), .clearToCodeN(l1.clearToCodeN));
	// Bits on the data wire at each falling shift edge
	always @(negedge clk)
	begin
		if (sPrev && !l1.shiftClk)
			wireSeen <= {wireSeen[22:0], l1.serialInLine};
		sPrev <= l1.shiftClk;
	end
	task automatic finish_test();
		$display("checked %0d, mismatched %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [62:0] seen, input logic [62:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic xfer(input logic [23:0] f);
		int n;
		chk("ready", reqReady, 1'b1);
		@(posedge clk);
		reqFrame <= f;
		reqValid <= 1'b1;
		@(posedge clk);
		reqValid <= 1'b0;
		@(negedge clk);
		chk("busy", reqReady, 1'b0);
		for (n = 0; n < 400 && rspValid !== 1'b1; n++)
			@(negedge clk);
		if (n == 400)
		begin
			err_total++;
			finish_test();
		end
		repeat (8) @(negedge clk);
	endtask : xfer
	task automatic pins(input logic l, input logic c, input logic r);
		@(posedge clk);
		ldN <= l;
		clrN <= c;
		rstN <= r;
		repeat (8) @(negedge clk);
	endtask : pins
	// Hand-made frame of n falling edges on the second link
	task automatic raw(input int n, input logic e);
		@(posedge clk);
		l2.frameSelN <= 1'b0;
		repeat (n)
		begin
			repeat (4) @(posedge clk);
			l2.shiftClk <= 1'b0;
			repeat (4) @(posedge clk);
			l2.shiftClk <= 1'b1;
		end
		repeat (4) @(posedge clk);
		l2.frameSelN <= 1'b1;
		repeat (8) @(negedge clk);
		chk("frame error", fe2, e);
	endtask : raw
	initial
	begin
		l2.frameSelN = 1'b1;
		l2.shiftClk = 1'b1;
		l2.serialInLine = 1'b0;
		l2.loadOutputN = 1'b1;
		l2.clearToCodeN = 1'b1;
		l2.resetN = 1'b1;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(negedge clk);
		chk("code", code, 20'h00000);
		xfer(24'h180001);
		chk("wire", wireSeen, 24'h180001);
		chk("code", code, 20'h80001);
		chk("bin", bin, 14'h0001);
		chk("seg", seg, 63'hffffffff);
		chk("error", fe, 1'b0);
		xfer(24'h200010);
		chk("ctrl", ctrl, 20'h00010);
		xfer(24'h900000);
		xfer(24'ha00000);
		chk("read code", rspData, 24'h980001);
		xfer(24'h000000);
		chk("read ctrl", rspData, 24'ha00010);
		$display("write and read test done");
		pins(1'b1, 1'b1, 1'b1);
		xfer(24'h112345);
		chk("code", code, 20'h80001);
		pins(1'b0, 1'b1, 1'b1);
		chk("code", code, 20'h12345);
		xfer(24'h30abcd);
		pins(1'b1, 1'b0, 1'b1);
		chk("code", code, 20'h0abcd);
		xfer(24'h155555);
		chk("code", code, 20'h0abcd);
		pins(1'b1, 1'b1, 1'b1);
		chk("code", code, 20'h0abcd);
		pins(1'b0, 1'b1, 1'b1);
		xfer(24'h111111);
		chk("code", code, 20'h11111);
		xfer(24'h400002);
		chk("code", code, 20'h0abcd);
		xfer(24'h400004);
		chk("ctrl", ctrl, 20'h00000);
		$display("load and clear test done");
		pins(1'b0, 1'b1, 1'b0);
		xfer(24'h200010);
		chk("ctrl", ctrl, 20'h00000);
		pins(1'b0, 1'b1, 1'b1);
		xfer(24'h200020);
		xfer(24'ha00000);
		xfer(24'h000000);
		chk("read off", rspData, 24'hffffff);
		raw(23, 1'b1);
		raw(25, 1'b1);
		raw(24, 1'b0);
		$display("reset and frame test done");
		finish_test();
	end
endmodule : testbench
